// File: verilog/fic_pkg.sv
// Package of constants for the fast interrupt context swap block
`default_nettype none
package fic_pkg;
    // Register port offsets
    localparam logic [2:0] OFS_MODE      = 3'h0;
    localparam logic [2:0] OFS_VEC_HI    = 3'h1;
    localparam logic [2:0] OFS_VEC_LO    = 3'h2;
    localparam logic [2:0] OFS_FLAGS     = 3'h3;
    localparam logic [2:0] OFS_STATUS    = 3'h4;
    // System mode register fields
    localparam int         MODE_GIE_BIT  = 0;
    localparam int         MODE_FEN_BIT  = 1;
    localparam int         MODE_SEL_LSB  = 2;
    localparam int         SEL_WIDTH     = 3;
    // Flags register fields
    localparam int         FLAGS_FAST_BIT = 1;
    // Reset values
    localparam logic [7:0] MODE_RESET    = 8'h00;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [15:0] VEC_RESET    = 16'h0000;
    // Entry timing: fast entry cycles versus normal entry cycles
    localparam int         FAST_ENTRY_CYCLES   = 6;
    localparam int         NORMAL_ENTRY_CYCLES = 16;
    localparam int         LEVELS        = 8;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ENTRY,
        ST_RETURN
    } fic_state_type;
endpackage : fic_pkg
`default_nettype wire

// File: verilog/fic_level_match.sv
// Level selector: finds whether the taken level is the fast level
`default_nettype none
module fic_level_match (
    // Level inputs
    input  wire logic [7:0] level_onehot_in,
    input  wire logic [2:0] sel_in,
    // Result
    output logic            match_out
);
    logic [7:0] hit;
    genvar g;
    generate
        for (g = 0; g < fic_pkg::LEVELS; g++) begin : g_lvl
            assign hit[g] = level_onehot_in[g] && (sel_in == 3'(g));
        end
    endgenerate
    assign match_out = |hit;
endmodule : fic_level_match
`default_nettype wire

// File: verilog/fic_core.sv
// Fast interrupt context swap: pointer/counter exchange and flag shadowing
// Operation
// - Fast entry swaps pointer and program counter
// - Fast entry copies flags into shadow
// - Fast entry sets fast status flag
// - Fast return swaps pointer and counter back
// - Fast return restores flags from shadow
// - Fast return clears fast status flag
// - Fast works for either pending clear type
// - Only mode enable bit turns fast on
// - Global disable also blocks fast interrupts
// - Six cycle entry, any of eight levels
// - Status set blocks interrupts, return is fast
//
// Local design decisions: the plain strobed port and the placing of the registers.
`default_nettype none
module fic_core (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        clk_en_in,
    // Register port
    input  wire logic [2:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [7:0]       reg_rdata_out,
    // Sequencer side
    input  wire logic        irq_take_in,
    input  wire logic [7:0]  irq_level_in,
    input  wire logic        irq_return_in,
    input  wire logic        global_irq_on_in,
    input  wire logic        global_irq_off_in,
    input  wire logic [15:0] program_counter_in,
    input  wire logic [7:0]  flags_in,
    input  wire logic        flags_load_in,
    // Results to sequencer
    output logic [15:0]      program_counter_out,
    output logic             pc_load_out,
    output logic [7:0]       flags_out,
    output logic             irq_allow_out,
    output logic             fast_taken_out,
    output logic             busy_out
);
    logic [7:0]  system_mode_reg_q;
    logic [15:0] fast_vector_pointer_q;
    logic [7:0]  flags_q;
    logic [7:0]  shadow_flags_q;
    logic [2:0]  cnt_q;
    fic_pkg::fic_state_type state_q;
    logic [7:0]  rdata_q;
    logic [15:0] pc_out_q;
    logic        pc_load_q;
    logic        fast_taken_q;
    logic        busy_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic level_match;
    fic_level_match i_fic_level_match (
        .level_onehot_in (irq_level_in),
        .sel_in          (system_mode_reg_q[fic_pkg::MODE_SEL_LSB +: fic_pkg::SEL_WIDTH]),
        .match_out       (level_match)
    );
    wire fast_active   = flags_q[fic_pkg::FLAGS_FAST_BIT];
    wire gie           = system_mode_reg_q[fic_pkg::MODE_GIE_BIT];
    wire fast_en       = system_mode_reg_q[fic_pkg::MODE_FEN_BIT];
    // Pending clear type is not consulted, so both kinds qualify
    wire start_fast    = (state_q == fic_pkg::ST_IDLE) && irq_take_in && gie
                         && !fast_active && fast_en && level_match;
    wire start_return  = (state_q == fic_pkg::ST_IDLE) && irq_return_in
                         && fast_active;
    wire wr_mode       = reg_wr_in && (reg_addr_in == fic_pkg::OFS_MODE);
    wire wr_vhi        = reg_wr_in && (reg_addr_in == fic_pkg::OFS_VEC_HI);
    wire wr_vlo        = reg_wr_in && (reg_addr_in == fic_pkg::OFS_VEC_LO);
    wire wr_flags      = reg_wr_in && (reg_addr_in == fic_pkg::OFS_FLAGS);
    wire last_cycle    = (cnt_q == 3'(fic_pkg::FAST_ENTRY_CYCLES - 1));
    // Status bits: 1 = sequence running, 0 = fast routine active
    wire [7:0] status  = {6'h00, state_q != fic_pkg::ST_IDLE, fast_active};
    // Unmapped indexes read as zero
    wire [7:0] rd_mux  = (reg_addr_in == fic_pkg::OFS_MODE)   ? system_mode_reg_q :
                         (reg_addr_in == fic_pkg::OFS_VEC_HI) ? fast_vector_pointer_q[15:8] :
                         (reg_addr_in == fic_pkg::OFS_VEC_LO) ? fast_vector_pointer_q[7:0] :
                         (reg_addr_in == fic_pkg::OFS_FLAGS)  ? flags_q :
                         (reg_addr_in == fic_pkg::OFS_STATUS) ? status : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Next values of the two bits that gate acceptance; the allow flag is
    // built from them so it never lags a flag load or a global pulse
    wire gie_d         = global_irq_on_in  ? 1'b1 :
                         global_irq_off_in ? 1'b0 :
                         wr_mode           ? reg_wdata_in[fic_pkg::MODE_GIE_BIT] : gie;
    wire fast_d        = start_fast    ? 1'b1 :
                         start_return  ? 1'b0 :
                         flags_load_in ? flags_in[fic_pkg::FLAGS_FAST_BIT] :
                         wr_flags      ? reg_wdata_in[fic_pkg::FLAGS_FAST_BIT] : fast_active;
    // Busy covers the whole fixed-length sequence, registered for the port
    wire busy_d        = start_fast || start_return
                         || ((state_q != fic_pkg::ST_IDLE) && !last_cycle);
    // Return image: shadow copy with the status bit forced clear
    logic [7:0] flags_restore;
    always_comb begin
        flags_restore = shadow_flags_q;
        flags_restore[fic_pkg::FLAGS_FAST_BIT] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode register; only software writes move the fast enable bit
    // Global pulses win bit 0 over a same-cycle software write
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            system_mode_reg_q <= fic_pkg::MODE_RESET;
        end else if (clk_en_in) begin
            if (wr_mode) begin
                system_mode_reg_q <= reg_wdata_in;
            end
            if (global_irq_on_in) begin
                system_mode_reg_q[fic_pkg::MODE_GIE_BIT] <= 1'b1;
            end else if (global_irq_off_in) begin
                system_mode_reg_q[fic_pkg::MODE_GIE_BIT] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer: swapped with the counter on entry and return
    // After a return it holds the counter value taken at return until software reloads it or the next fast entry swaps it
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fast_vector_pointer_q <= fic_pkg::VEC_RESET;
        end else if (clk_en_in) begin
            if (start_fast || start_return) begin
                fast_vector_pointer_q <= program_counter_in;
            end else if (wr_vhi) begin
                fast_vector_pointer_q[15:8] <= reg_wdata_in;
            end else if (wr_vlo) begin
                fast_vector_pointer_q[7:0] <= reg_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags and shadow; hardware updates win over software writes
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_q        <= fic_pkg::FLAGS_RESET;
            shadow_flags_q <= fic_pkg::FLAGS_RESET;
        end else if (clk_en_in) begin
            if (start_fast) begin
                shadow_flags_q <= flags_q;
                flags_q[fic_pkg::FLAGS_FAST_BIT] <= 1'b1;
            end else if (start_return) begin
                flags_q <= flags_restore;
            end else if (flags_load_in) begin
                flags_q <= flags_in;
            end else if (wr_flags) begin
                flags_q <= reg_wdata_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence: counter load is a single-cycle swap, busy spans the entry
    // A low clock enable stretches the sequence by whole cycles
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q      <= fic_pkg::ST_IDLE;
            cnt_q        <= 3'h0;
            pc_out_q     <= 16'h0000;
            pc_load_q    <= 1'b0;
            fast_taken_q <= 1'b0;
            busy_q       <= 1'b0;
        end else if (clk_en_in) begin
            // Pulses last one enabled cycle each
            pc_load_q    <= start_fast || start_return;
            fast_taken_q <= start_fast;
            busy_q       <= busy_d;
            if (start_fast || start_return) begin
                pc_out_q <= fast_vector_pointer_q;
            end
            case (state_q)
                fic_pkg::ST_IDLE: begin
                    cnt_q <= 3'h0;
                    if (start_fast) begin
                        state_q <= fic_pkg::ST_ENTRY;
                    end else if (start_return) begin
                        state_q <= fic_pkg::ST_RETURN;
                    end
                end
                default: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (last_cycle) begin
                        state_q <= fic_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and allow flag
    logic allow_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_q <= 8'h00;
            allow_q <= 1'b0;
        end else if (clk_en_in) begin
            // Read data stands for one cycle only; idle cycles read as zero
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
            allow_q <= gie_d && !fast_d;
        end
    end

    assign reg_rdata_out       = rdata_q;
    assign program_counter_out = pc_out_q;
    assign pc_load_out         = pc_load_q;
    assign flags_out           = flags_q;
    assign irq_allow_out       = allow_q;
    assign fast_taken_out      = fast_taken_q;
    assign busy_out            = busy_q;
endmodule : fic_core
`default_nettype wire

// File: bench/fic_core_props.sv
// Assertion checker for the fast interrupt context swap block
`default_nettype none
module fic_core_props (
    // Clock and reset
    input wire logic       ref_clk_in,
    input wire logic       reset_n_in,
    // Sequencer requests
    input wire logic       irq_take_in,
    input wire logic       irq_return_in,
    input wire logic       global_irq_on_in,
    input wire logic       global_irq_off_in,
    // Results
    input wire logic       pc_load_out,
    input wire logic [7:0] flags_out,
    input wire logic       irq_allow_out,
    input wire logic       fast_taken_out,
    input wire logic       busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_entry_effects: assert property (fast_taken_out |-> pc_load_out && flags_out[1])
        else $error("fast entry without load or status flag");
    a_entry_cause: assert property (fast_taken_out |-> $past(irq_take_in))
        else $error("fast entry without a taken interrupt");
    a_busy_six: assert property ($rose(busy_out) |-> busy_out[*6] ##1 !busy_out)
        else $error("sequence length is not six cycles");
    a_status_blocks: assert property (flags_out[1] |-> !irq_allow_out)
        else $error("interrupts allowed while fast status set");
    a_nest_refused: assert property (flags_out[1] && irq_take_in |=> !fast_taken_out)
        else $error("second fast entry while status set");
    a_global_off: assert property (global_irq_off_in && !global_irq_on_in
        |-> ##2 !fast_taken_out)
        else $error("fast entry while globally disabled");
    a_return_swap: assert property (irq_return_in && flags_out[1] && !busy_out
        |=> pc_load_out && !flags_out[1])
        else $error("fast return did not swap or clear status");
    a_normal_return: assert property (irq_return_in && !flags_out[1] && !irq_take_in
        |=> !pc_load_out)
        else $error("swap on a normal return");
    cover property (fast_taken_out);
    cover property (irq_return_in && flags_out[1]);
    cover property (global_irq_off_in);
endmodule : fic_core_props
`default_nettype wire

// File: bench/fic_seq_model.sv
// Far-side model: program counter of the instruction sequencer
`default_nettype none
module fic_seq_model #(
    parameter logic [15:0] START_PC = 16'h0100
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        pc_load_in,
    input  wire logic [15:0] pc_new_in,
    output logic [15:0]      pc_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Counter holds between loads so every swap shows at once, no stack involved
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_out <= START_PC;
        end else if (pc_load_in) begin
            pc_out <= pc_new_in;
        end
    end
endmodule : fic_seq_model
`default_nettype wire

// File: bench/fic_core_bench.sv
// Self-checking bench for the fast interrupt context swap block
`default_nettype none
module fic_core_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in, reset_n_in = '0, clk_en_in = 1'h1, reg_wr_in = '0, reg_rd_in = '0;
    logic irq_take_in = '0, irq_return_in = '0, global_irq_on_in = '0, global_irq_off_in = '0;
    logic flags_load_in = '0, pc_load_out, irq_allow_out, fast_taken_out, busy_out, rd_q = '0;
    logic [2:0]  reg_addr_in = '0;
    logic [7:0]  reg_wdata_in = '0, irq_level_in = '0, flags_in = '0, reg_rdata_out, flags_out, f;
    logic [15:0] program_counter_in, program_counter_out, vec, saved, cur = 16'h0100;
    logic [31:0] seed = 32'hC2628814;
    logic [15:0] exp_pc[$], exp_rd[$];
    int          bad_count = 0, comparisons = 0;
    fic_core i_fic_core (.ref_clk_in, .reset_n_in, .clk_en_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_take_in, .irq_level_in, .irq_return_in,
        .global_irq_on_in, .global_irq_off_in, .program_counter_in, .flags_in, .flags_load_in,
        .program_counter_out, .pc_load_out, .flags_out, .irq_allow_out, .fast_taken_out,
        .busy_out);
    fic_seq_model i_fic_seq_model (.ref_clk_in, .reset_n_in, .pc_load_in(pc_load_out),
        .pc_new_in(program_counter_out), .pc_out(program_counter_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(logic [15:0] seen, logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic conclude();
        $display("compared %0d, wrong %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge ref_clk_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'h1};
        @(posedge ref_clk_in) reg_wr_in <= '0;
    endtask : wr
    task automatic rd(logic [2:0] a, logic [7:0] e);
        exp_rd.push_back({8'h00, e});
        @(posedge ref_clk_in) {reg_addr_in, reg_rd_in} <= {a, 1'h1};
        @(posedge ref_clk_in) reg_rd_in <= '0;
    endtask : rd
    // Expected counter values are tracked here, never read back from the model
    task automatic take(logic [7:0] lv, bit hit);
        if (hit) begin
            exp_pc.push_back(vec);
            saved = cur;
            cur = vec;
        end
        @(posedge ref_clk_in) {irq_level_in, irq_take_in} <= {lv, 1'h1};
        @(posedge ref_clk_in) irq_take_in <= '0;
    endtask : take
    task automatic ret(bit hit);
        repeat (6) @(posedge ref_clk_in);
        if (hit) begin
            exp_pc.push_back(saved);
            cur = saved;
        end
        @(posedge ref_clk_in) irq_return_in <= 1'h1;
        @(posedge ref_clk_in) irq_return_in <= '0;
    endtask : ret
    task automatic glob(bit on);
        @(posedge ref_clk_in) {global_irq_on_in, global_irq_off_in} <= {on, !on};
        @(posedge ref_clk_in) {global_irq_on_in, global_irq_off_in} <= '0;
    endtask : glob
    task automatic load_flags(logic [7:0] v);
        @(posedge ref_clk_in) {flags_in, flags_load_in} <= {v, 1'h1};
        @(posedge ref_clk_in) flags_load_in <= '0;
    endtask : load_flags
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = '0;
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) rd_q <= reg_rd_in;
    // An unexpected load compares against unknown and so always counts as wrong
    always @(negedge ref_clk_in) begin
        if (reset_n_in && pc_load_out !== 1'h0) begin
            chk(program_counter_out, exp_pc.size() ? exp_pc.pop_front() : 'x);
        end
        if (rd_q) chk({8'h00, reg_rdata_out}, exp_rd.pop_front());
    end
    initial begin
        repeat (4000) @(posedge ref_clk_in);
        bad_count++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        reset_n_in <= 1'h1;
        rd(fic_pkg::OFS_MODE, fic_pkg::MODE_RESET);
        rd(3'h7, 8'h00);
        wr(3'h7, 8'hFF);
        rd(fic_pkg::OFS_STATUS, 8'h00);
        // A write while the clock enable is low must leave the pointer alone
        @(posedge ref_clk_in) clk_en_in <= '0;
        wr(fic_pkg::OFS_VEC_HI, 8'hA5);
        @(posedge ref_clk_in) clk_en_in <= 1'h1;
        rd(fic_pkg::OFS_VEC_HI, fic_pkg::VEC_RESET[15:8]);
        for (int l = 0; l < 8; l++) begin
            seed = lfsr(seed);
            vec = seed[15:0];
            f = seed[23:16] & 8'hFD;
            wr(fic_pkg::OFS_VEC_HI, vec[15:8]);
            wr(fic_pkg::OFS_VEC_LO, vec[7:0]);
            wr(fic_pkg::OFS_MODE, 8'({l[2:0], 2'h3}));
            load_flags(f);
            take(8'h01 << ((l + 1) % 8), 0);
            take(8'h01 << l, 1);
            take(8'h01 << l, 0);
            rd(fic_pkg::OFS_FLAGS, f | 8'h02);
            @(negedge ref_clk_in) chk(16'(irq_allow_out), 16'h0000);
            // The routine changes the flags, so only the shadow can bring f back
            load_flags(~f | 8'h02);
            ret(1);
            rd(fic_pkg::OFS_FLAGS, f);
            @(negedge ref_clk_in) chk(16'(irq_allow_out), 16'h0001);
            ret(0);
        end
        wr(fic_pkg::OFS_MODE, 8'h1D);
        take(8'h80, 0);
        wr(fic_pkg::OFS_MODE, 8'h1F);
        glob(0);
        @(negedge ref_clk_in) chk(16'(irq_allow_out), 16'h0000);
        take(8'h80, 0);
        glob(1);
        @(negedge ref_clk_in) chk(16'(irq_allow_out), 16'h0001);
        take(8'h80, 1);
        ret(1);
        repeat (4) @(posedge ref_clk_in);
        chk(16'(exp_pc.size()), 16'h0000);
        conclude();
    end
endmodule : fic_core_bench
bind fic_core fic_core_props i_fic_core_props (.ref_clk_in, .reset_n_in, .irq_take_in,
    .irq_return_in, .global_irq_on_in, .global_irq_off_in, .pc_load_out, .flags_out,
    .irq_allow_out, .fast_taken_out, .busy_out);
`default_nettype wire
